// *** src/psc_pkg.sv ***
package psc_pkg;
   localparam logic [31:0] ADDR_UNLOCK_KEY = 32'h02AC0004;
   localparam logic [31:0] ADDR_CFG_A      = 32'h02AC0008;
   localparam logic [31:0] ADDR_STAT_A     = 32'h02AC0014;
   localparam logic [31:0] ADDR_STAT_B     = 32'h02AC0018;
   localparam logic [31:0] ADDR_ETH_CFG    = 32'h02AC0020;
   localparam logic [31:0] ADDR_CFG_B      = 32'h02AC002C;
   localparam logic [31:0] ADDR_DBG_PD     = 32'h02AC0054;
   localparam logic [31:0] UNLOCK_KEY      = 32'h0F0A0B00;
   localparam logic [31:0] RST_UNLOCK_KEY  = 32'hF0F0F0F0;
   localparam logic [31:0] RST_ZERO        = 32'h00000000;
   localparam int          WINDOW_CYCLES   = 16;
   localparam logic [4:0]  WINDOW_COUNT    = 5'(WINDOW_CYCLES);
   localparam int          NUM_PER         = 10;
   // Peripheral indices; main config bit positions follow.
   localparam int P_ETHERNET_CONTROLLER  = 0;
   localparam int P_TMR1  = 1;
   localparam int P_TMR0  = 2;
   localparam int P_GPIO  = 3;
   localparam int P_I2C   = 4;
   localparam int P_SER0  = 5;
   localparam int P_SER1  = 6;
   localparam int P_HOST  = 7;
   localparam int P_PCI   = 8;
   localparam int P_MEM   = 9;
   localparam int CFGA_ETHERNET_CONTROLLER_BIT = 4;
   localparam int CFGA_TMR1_BIT = 6;
   localparam int CFGA_TMR0_BIT = 8;
   localparam int CFGA_GPIO_BIT = 10;
   localparam int CFGA_I2C_BIT  = 12;
   localparam int CFGA_SER0_BIT = 14;
   localparam int CFGA_SER1_BIT = 16;
   localparam int CFGA_HOST_BIT = 18;
   localparam int CFGA_PCI_BIT  = 20;
   localparam int CFGB_EXT_MEM_BIT = 0;
   localparam int CFGB_DRAM_BIT    = 1;
   localparam logic [31:0] CFGA_MASK = 32'h00155550;
   localparam logic [31:0] CFGB_MASK = 32'h00000003;
   // Status: two bits per peripheral, A holds 0..7 from bit 0, B holds host and PCI.
   localparam int STAT_FIELD_W = 2;

   typedef enum logic [1:0] {
      PSC_DISABLED  = 2'b00,
      PSC_IN_PROG   = 2'b01,
      PSC_ENABLED   = 2'b11,
      PSC_POWERDOWN = 2'b10
   } psc_state_t;

   typedef enum logic [1:0] {
      PSC_MII   = 2'b00,
      PSC_RMII  = 2'b01,
      PSC_GMII  = 2'b10,
      PSC_RGMII = 2'b11
   } psc_eth_if_t;

   typedef struct packed {
      logic        pci_select;
      logic        bus_speed;
      logic        eeprom_autoinit;
      logic        host_width;
      logic [1:0]  ethernet_interface;
      logic        serial_one_pins;
      logic        ext_mem_pins;
      logic        dram_pins;
      logic        host_boot;
      logic        pci_boot;
   } psc_strap_t;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        master_ok;
      logic [31:0] addr;
      logic [31:0] wdata;
   } psc_bus_req_t;
endpackage

// *** src/psc_top.sv ***
`timescale 1ns/1ns
module psc_top #(
   parameter int NPER = psc_pkg::NUM_PER
) (
   // Clock, reset and enable.
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_ce,
   // Straps, steady around the reset release.
   input  wire psc_pkg::psc_strap_t   i_strap,
   // Register port from the CPU and emulator.
   input  wire psc_pkg::psc_bus_req_t i_bus,
   output logic [31:0]                o_rdata,
   output logic                       o_rvalid,
   // Peripheral controls.
   output logic [NPER-1:0]            o_per_clk_en,
   output logic [NPER-1:0]            o_per_rst_b,
   output logic                       o_ext_mem_en,
   output logic                       o_dram_en,
   // Pin muxing and options.
   output logic                       o_pci_pins,
   output logic                       o_host_lower_en,
   output logic                       o_host_upper_en,
   output logic                       o_pci_66mhz,
   output logic                       o_pci_eeprom_load,
   output psc_pkg::psc_eth_if_t       o_eth_if
);
   import psc_pkg::*;

   logic               strap_done;
   psc_strap_t         strap;
   logic [31:0]        unlock_key;
   logic [31:0]        cfg_a;
   logic [31:0]        cfg_b;
   logic [31:0]        eth_cfg;
   logic [31:0]        dbg_pd;
   logic [4:0]         window;
   psc_state_t         st [NPER];
   logic [NPER-1:0]    pins_ok;
   logic [NPER-1:0]    req_en;
   logic               acc;
   logic               wr_cfg_a;
   logic [31:0]        next_rdata;

   function automatic logic hit(input logic [31:0] a);
      return acc && i_bus.wr && (i_bus.addr == a);
   endfunction

   // Only the CPU and emulator qualify an access.
   assign acc      = i_bus.sel && i_bus.master_ok;
   assign wr_cfg_a = hit(ADDR_CFG_A) && (window != 5'h00);

   // Straps are captured on the first enabled edge after release, never at reset.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         strap_done <= 1'b0;
         strap      <= '0;
      end else if (i_ce && !strap_done) begin
         strap_done <= 1'b1;
         strap      <= i_strap;
      end
   end

   always_comb begin
      pins_ok         = '1;
      pins_ok[P_HOST] = !strap.pci_select;
      pins_ok[P_PCI]  = strap.pci_select;
      pins_ok[P_SER1] = strap.serial_one_pins;
      pins_ok[P_MEM]  = strap.ext_mem_pins | strap.dram_pins;
   end

   always_comb begin
      req_en         = '0;
      req_en[P_ETHERNET_CONTROLLER] = cfg_a[CFGA_ETHERNET_CONTROLLER_BIT];
      req_en[P_TMR1] = cfg_a[CFGA_TMR1_BIT];
      req_en[P_TMR0] = cfg_a[CFGA_TMR0_BIT];
      req_en[P_GPIO] = cfg_a[CFGA_GPIO_BIT];
      req_en[P_I2C]  = cfg_a[CFGA_I2C_BIT];
      req_en[P_SER0] = cfg_a[CFGA_SER0_BIT];
      req_en[P_SER1] = cfg_a[CFGA_SER1_BIT];
      req_en[P_HOST] = cfg_a[CFGA_HOST_BIT];
      req_en[P_PCI]  = cfg_a[CFGA_PCI_BIT];
      req_en[P_MEM]  = |cfg_b[1:0];
   end

   // Key register and the one-write window.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         unlock_key <= RST_UNLOCK_KEY;
         window     <= 5'h00;
      end else if (i_ce) begin
         if (hit(ADDR_UNLOCK_KEY)) begin
            unlock_key <= i_bus.wdata;
            window     <= (i_bus.wdata == UNLOCK_KEY) ? WINDOW_COUNT : 5'h00;
         end else if (wr_cfg_a) begin
            window <= 5'h00;
         end else if (window != 5'h00) begin
            window <= window - 5'h01;
         end
      end
   end

   // Main configuration; boot peripherals default enabled.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_a <= RST_ZERO;
      end else if (i_ce) begin
         if (!strap_done) begin
            cfg_a[CFGA_HOST_BIT] <= i_strap.host_boot;
            cfg_a[CFGA_PCI_BIT]  <= i_strap.pci_boot;
         end else if (wr_cfg_a) begin
            cfg_a <= i_bus.wdata & CFGA_MASK;
         end
      end
   end

   // Second configuration: direct write, set bits stick.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_b   <= RST_ZERO;
         eth_cfg <= RST_ZERO;
         dbg_pd  <= RST_ZERO;
      end else if (i_ce) begin
         if (hit(ADDR_CFG_B)) begin
            cfg_b <= cfg_b | (i_bus.wdata & CFGB_MASK);
         end
         if (hit(ADDR_ETH_CFG)) begin
            eth_cfg <= i_bus.wdata;
         end
         if (hit(ADDR_DBG_PD)) begin
            dbg_pd <= i_bus.wdata;
         end
      end
   end

   // Peripheral state machines. Progress lasts one cycle while clock starts under reset.
   for (genvar g = 0; g < NPER; g++) begin : g_per
      always_ff @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            st[g] <= PSC_DISABLED;
         end else if (i_ce && strap_done) begin
            case (st[g])
               PSC_DISABLED: begin
                  if (!pins_ok[g]) begin
                     st[g] <= PSC_POWERDOWN;
                  end else if (req_en[g]) begin
                     st[g] <= PSC_IN_PROG;
                  end
               end
               PSC_IN_PROG: begin
                  st[g] <= req_en[g] ? PSC_ENABLED : PSC_DISABLED;
               end
               PSC_ENABLED: begin
                  if (!req_en[g]) begin
                     st[g] <= PSC_DISABLED;
                  end
               end
               PSC_POWERDOWN: begin
                  st[g] <= PSC_POWERDOWN;
               end
               default: begin
                  st[g] <= PSC_DISABLED;
               end
            endcase
         end
      end
   end

   // Outputs registered from state and latched straps.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_per_clk_en      <= '0;
         o_per_rst_b       <= '0;
         o_ext_mem_en      <= 1'b0;
         o_dram_en         <= 1'b0;
         o_pci_pins        <= 1'b0;
         o_host_lower_en   <= 1'b0;
         o_host_upper_en   <= 1'b0;
         o_pci_66mhz       <= 1'b0;
         o_pci_eeprom_load <= 1'b0;
         o_eth_if          <= PSC_MII;
      end else if (i_ce) begin
         for (int k = 0; k < NPER; k++) begin
            o_per_clk_en[k] <= (st[k] == PSC_IN_PROG) || (st[k] == PSC_ENABLED);
            o_per_rst_b[k]  <= (st[k] == PSC_ENABLED);
         end
         o_ext_mem_en      <= (st[P_MEM] == PSC_ENABLED) && cfg_b[CFGB_EXT_MEM_BIT]
                              && strap.ext_mem_pins;
         o_dram_en         <= (st[P_MEM] == PSC_ENABLED) && cfg_b[CFGB_DRAM_BIT]
                              && strap.dram_pins;
         o_pci_pins        <= strap_done && strap.pci_select;
         o_host_lower_en   <= strap_done && !strap.pci_select;
         o_host_upper_en   <= strap_done && !strap.pci_select && strap.host_width;
         o_pci_66mhz       <= strap.pci_select && strap.bus_speed;
         o_pci_eeprom_load <= strap.pci_select && strap.eeprom_autoinit;
         o_eth_if          <= psc_eth_if_t'(strap.ethernet_interface);
      end
   end

   // Read path, one cycle latency; unmapped reads return zero.
   always_comb begin
      next_rdata = RST_ZERO;
      case (i_bus.addr)
         ADDR_UNLOCK_KEY: next_rdata = unlock_key;
         ADDR_CFG_A:      next_rdata = cfg_a;
         ADDR_STAT_A: begin
            for (int k = 0; k < 8; k++) begin
               next_rdata[k*STAT_FIELD_W +: STAT_FIELD_W] = st[k];
            end
         end
         ADDR_STAT_B: begin
            next_rdata[1:0] = st[P_HOST];
            next_rdata[3:2] = st[P_PCI];
         end
         ADDR_ETH_CFG:    next_rdata = eth_cfg;
         ADDR_CFG_B:      next_rdata = cfg_b;
         ADDR_DBG_PD:     next_rdata = dbg_pd;
         default:         next_rdata = RST_ZERO;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata  <= RST_ZERO;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= acc && !i_bus.wr;
         o_rdata  <= (acc && !i_bus.wr) ? next_rdata : RST_ZERO;
      end
   end

   // Assertions.
   sequence s_key_write;
      hit(ADDR_UNLOCK_KEY) && i_bus.wdata == UNLOCK_KEY;
   endsequence

   a_window_opens: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (s_key_write and i_ce) |=> window == WINDOW_COUNT)
      else $error("window did not open after key");
   // A stalled clock enable must not eat into the key window.
   a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_ce |=> $stable(window) && $stable(cfg_a) && $stable(o_per_clk_en))
      else $error("state moved while clock enable low");
   a_window_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      window <= WINDOW_COUNT)
      else $error("window count exceeds limit");
   a_window_close: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && wr_cfg_a && !hit(ADDR_UNLOCK_KEY) |=> window == 5'h00)
      else $error("window still open after write");
   a_locked_cfg: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      strap_done && window == 5'h00 && !hit(ADDR_UNLOCK_KEY) |=> $stable(cfg_a))
      else $error("main config changed while locked");
   a_sticky_cfgb: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (cfg_b & $past(cfg_b)) == $past(cfg_b))
      else $error("sticky enable cleared");
   a_powerdown_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && st[P_PCI] == PSC_POWERDOWN |=> !o_per_clk_en[P_PCI] && !o_per_rst_b[P_PCI])
      else $error("powered-down peripheral active");
   a_enable_path: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st[P_TMR0] == PSC_DISABLED ##1 st[P_TMR0] != PSC_DISABLED
      |-> st[P_TMR0] inside {PSC_IN_PROG, PSC_POWERDOWN})
      else $error("enable skipped in-progress state");
   a_strap_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      strap_done |=> $stable(strap))
      else $error("latched strap changed");
   a_host_pci_excl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !(o_pci_pins && o_host_lower_en))
      else $error("host and PCI both own pins");
   a_speed_pci: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_pci_66mhz |-> strap.pci_select)
      else $error("speed set without PCI");
endmodule

// *** sim/peripheral_state_control_tb.sv ***
`timescale 1ns/1ns
module peripheral_state_control_tb;
   import psc_pkg::*;
   logic               i_clk;
   logic               i_rst_b;
   logic               i_ce;
   psc_strap_t         i_strap;
   psc_bus_req_t       i_bus;
   logic [31:0]        o_rdata;
   logic               o_rvalid;
   logic [NUM_PER-1:0] o_per_clk_en;
   logic [NUM_PER-1:0] o_per_rst_b;
   logic               o_ext_mem_en;
   logic               o_dram_en;
   logic               o_pci_pins;
   logic               o_host_lower_en;
   logic               o_host_upper_en;
   logic               o_pci_66mhz;
   logic               o_pci_eeprom_load;
   psc_eth_if_t        o_eth_if;
   int                 n_fail;
   int                 n_compared;
   int                 cyc;
   int                 i;
   logic [31:0]        rnd;
   logic [31:0]        v;
   logic [31:0]        cfga;
   logic [1:0]         cfgb;
   psc_strap_t         st;

   psc_top dut_u (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_strap(i_strap), .i_bus(i_bus),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_per_clk_en(o_per_clk_en),
      .o_per_rst_b(o_per_rst_b), .o_ext_mem_en(o_ext_mem_en), .o_dram_en(o_dram_en),
      .o_pci_pins(o_pci_pins), .o_host_lower_en(o_host_lower_en),
      .o_host_upper_en(o_host_upper_en), .o_pci_66mhz(o_pci_66mhz),
      .o_pci_eeprom_load(o_pci_eeprom_load), .o_eth_if(o_eth_if)
   );

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   // Expected settled state of one peripheral from the latched straps and requests.
   function automatic psc_state_t exp_st(input int k);
      logic pin;
      logic req;
      pin = (k == P_SER1) ? st.serial_one_pins : (k == P_HOST) ? !st.pci_select :
            (k == P_PCI) ? st.pci_select : (k == P_MEM) ? (st.ext_mem_pins | st.dram_pins) : 1'b1;
      req = (k == P_MEM) ? |cfgb : cfga[4 + 2 * k];
      if (!pin) return PSC_POWERDOWN;
      return req ? PSC_ENABLED : PSC_DISABLED;
   endfunction

   task automatic wrap_up();
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One bus cycle: the request set here is taken at the next rising edge.
   task automatic op(input logic s, input logic w, input logic ok, input logic [31:0] a,
                     input logic [31:0] d);
      @(posedge i_clk);
      i_bus <= {s, w, ok, a, d};
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      op(1'b1, 1'b1, 1'b1, a, d);
      op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
   endtask

   task automatic rd(input string what, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      op(1'b1, 1'b0, 1'b1, a, 32'h00000000);
      op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
      #1;
      chk(what, 32'h00000001, {31'h0, o_rvalid});
      chk(what, exp & m, o_rdata & m);
   endtask

   // Key, idle gap, then two configuration writes; only the first may land.
   task automatic unlock(input logic [31:0] key, input logic ok, input int gap,
                         input logic [31:0] d, input logic [31:0] d2);
      op(1'b1, 1'b1, ok, ADDR_UNLOCK_KEY, key);
      repeat (gap) op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
      op(1'b1, 1'b1, 1'b1, ADDR_CFG_A, d);
      op(1'b1, 1'b1, 1'b1, ADDR_CFG_A, d2);
      op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
   endtask

   task automatic check_all();
      logic [31:0] sa;
      logic [31:0] sb;
      sa = 32'h00000000;
      repeat (6) @(posedge i_clk);
      #1;
      for (int k = 0; k < NUM_PER; k++) begin
         chk("clk_en", {31'h0, exp_st(k) == PSC_ENABLED}, {31'h0, o_per_clk_en[k]});
         chk("rst_b", {31'h0, exp_st(k) == PSC_ENABLED}, {31'h0, o_per_rst_b[k]});
         if (k < 7) sa[2*k +: 2] = exp_st(k);
      end
      sb = {28'h0, exp_st(P_PCI), exp_st(P_HOST)};
      chk("ext_mem_en", {31'h0, exp_st(P_MEM) == PSC_ENABLED && cfgb[0] && st.ext_mem_pins},
          {31'h0, o_ext_mem_en});
      chk("dram_en", {31'h0, exp_st(P_MEM) == PSC_ENABLED && cfgb[1] && st.dram_pins},
          {31'h0, o_dram_en});
      rd("status_a", ADDR_STAT_A, 32'h00003FFF, sa);
      rd("status_b", ADDR_STAT_B, 32'h0000000F, sb);
   endtask

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      rnd = 32'h0000283E;
      i_rst_b = 1'b0;
      i_ce = 1'b1;
      i_strap = '0;
      i_bus = '0;
      for (int it = 0; it < 6; it++) begin
         rnd = lfsr(rnd);
         st = psc_strap_t'(rnd[10:0]);
         st.ethernet_interface = 2'(it);
         if (it < 2) begin
            st.pci_select = it[0];
            st.host_boot = 1'b1;
            st.pci_boot = 1'b1;
         end
         @(posedge i_clk);
         i_rst_b <= 1'b0;
         i_strap <= st;
         repeat (12) @(posedge i_clk);
         i_rst_b <= 1'b1;
         repeat (3) @(posedge i_clk);
         // Straps move after the latch; outputs must not follow them.
         i_strap <= psc_strap_t'(~st);
         cfga = {11'h0, st.pci_boot, 1'b0, st.host_boot, 18'h0};
         cfgb = 2'b00;
         repeat (3) @(posedge i_clk);
         #1;
         chk("options", {25'h0, st.pci_select, !st.pci_select, !st.pci_select & st.host_width,
             st.pci_select & st.bus_speed, st.pci_select & st.eeprom_autoinit,
             st.ethernet_interface}, {25'h0, o_pci_pins, o_host_lower_en, o_host_upper_en,
             o_pci_66mhz, o_pci_eeprom_load, o_eth_if});
         check_all();
         rd("key_reset", ADDR_UNLOCK_KEY, 32'hFFFFFFFF, RST_UNLOCK_KEY);
         rd("unmapped", 32'h02AC000C, 32'hFFFFFFFF, 32'h00000000);
         wr(ADDR_CFG_A, lfsr(rnd));
         unlock(UNLOCK_KEY, 1'b0, 0, ~rnd, rnd);
         unlock(~UNLOCK_KEY, 1'b1, 0, lfsr(~rnd), rnd);
         unlock(UNLOCK_KEY, 1'b1, 16, rnd ^ 32'h00155550, rnd);
         rd("cfg_a_locked", ADDR_CFG_A, 32'hFFFFFFFF, cfga);
         rnd = lfsr(rnd);
         v = rnd | 32'h00150100;
         unlock(UNLOCK_KEY, 1'b1, 15, v, ~v);
         cfga = v & CFGA_MASK;
         #1;
         i = 0;
         while (o_per_clk_en[P_TMR0] !== 1'b1 && i < 8) begin
            @(posedge i_clk);
            #1;
            i++;
         end
         chk("in_prog", 32'h00000001, {31'h0, o_per_clk_en[P_TMR0] & ~o_per_rst_b[P_TMR0]});
         rd("cfg_a", ADDR_CFG_A, 32'hFFFFFFFF, cfga);
         check_all();
         rnd = lfsr(rnd);
         unlock(UNLOCK_KEY, 1'b1, 0, rnd, ~rnd);
         cfga = rnd & CFGA_MASK;
         rd("cfg_a_again", ADDR_CFG_A, 32'hFFFFFFFF, cfga);
         rd("key_back", ADDR_UNLOCK_KEY, 32'hFFFFFFFF, UNLOCK_KEY);
         // Key, then a long clock-enable stall; the frozen window must still accept.
         op(1'b1, 1'b1, 1'b1, ADDR_UNLOCK_KEY, UNLOCK_KEY);
         op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
         i_ce <= 1'b0;
         repeat (20) @(posedge i_clk);
         i_ce <= 1'b1;
         wr(ADDR_CFG_A, ~rnd);
         cfga = ~rnd & CFGA_MASK;
         rd("cfg_a_frozen", ADDR_CFG_A, 32'hFFFFFFFF, cfga);
         wr(ADDR_CFG_B, {30'h0, rnd[9:8]});
         cfgb = rnd[9:8];
         wr(ADDR_CFG_B, 32'h00000000);
         rd("cfg_b", ADDR_CFG_B, CFGB_MASK, {30'h0, cfgb});
         wr(ADDR_ETH_CFG, rnd);
         wr(ADDR_DBG_PD, ~rnd);
         wr(ADDR_STAT_A, rnd);
         rd("eth_cfg", ADDR_ETH_CFG, 32'hFFFFFFFF, rnd);
         rd("dbg_pd", ADDR_DBG_PD, 32'hFFFFFFFF, ~rnd);
         check_all();
      end
      wrap_up();
   end
endmodule
